// ---- common/dlc_pkg.sv ----
// Constants and types shared by the link control register bank.
// Assumes an 8-bit register space reached through a 32-bit word bus.
package dlc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] DLC_IDX_CTRL = 6'h04;
   localparam logic [5:0] DLC_IDX_EQ   = 6'h05;
   localparam logic [5:0] DLC_IDX_MISC = 6'h06;

   // Sleep and channel control fields
   localparam int DLC_CTRL_SLEEP_BIT = 4;
   localparam int DLC_CTRL_TYPE_LSB  = 2;
   localparam int DLC_CTRL_REV_BIT   = 1;
   localparam int DLC_CTRL_FWD_BIT   = 0;

   // Conversion and equalizer fields
   localparam int DLC_EQ_ADDR_BIT = 7;
   localparam int DLC_EQ_HPF_LSB  = 5;
   localparam int DLC_EQ_BOOST_POWER_DOWN_BIT = 4;
   localparam int DLC_EQ_GAIN_LSB = 0;

   // Miscellaneous fields
   localparam int DLC_MISC_STAG_BIT  = 7;
   localparam int DLC_MISC_AUTO_BIT  = 6;
   localparam int DLC_MISC_IRQD_BIT  = 5;
   localparam int DLC_MISC_IRQL_BIT  = 4;
   localparam int DLC_MISC_P1DRV_BIT = 3;
   localparam int DLC_MISC_P1LVL_BIT = 2;
   localparam int DLC_MISC_P0DRV_BIT = 1;
   localparam int DLC_MISC_P0LVL_BIT = 0;

   // Peripheral interface codes
   localparam logic [1:0] DLC_IFACE_I2C  = 2'h0;
   localparam logic [1:0] DLC_IFACE_UART = 2'h1;

   // Values after reset
   localparam logic [1:0] DLC_RST_IFACE   = 2'h0;
   localparam logic       DLC_RST_REV     = 1'b1;
   localparam logic       DLC_RST_FWD     = 1'b1;
   localparam logic       DLC_RST_ADDR    = 1'b0;
   localparam logic [1:0] DLC_RST_HPF     = 2'h1;
   localparam logic       DLC_RST_BOOST_POWER_DOWN    = 1'b0;
   localparam logic [3:0] DLC_GAIN_EQS_HI = 4'h4;
   localparam logic [3:0] DLC_GAIN_EQS_LO = 4'h9;
   localparam logic       DLC_RST_STAG    = 1'b0;
   localparam logic       DLC_RST_AUTO    = 1'b0;
   localparam logic       DLC_RST_IRQD    = 1'b0;
   localparam logic       DLC_RST_PDRV    = 1'b1;
   localparam logic       DLC_RST_SLEEP   = 1'b0;

   // Strap capture sequence; Gray along the path
   typedef enum logic [1:0] {
      DLC_ST_FILL0 = 2'b00,
      DLC_ST_FILL1 = 2'b01,
      DLC_ST_LOAD  = 2'b11,
      DLC_ST_RUN   = 2'b10
   } dlc_strap_t;

endpackage : dlc_pkg

// ---- common/dlc_reg_if.sv ----
// Internal register access strobes between bus slave and register bank.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface dlc_reg_if;
   logic       rd;
   logic       wr;
   logic [5:0] index;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       ready;

   modport slave (output rd, output wr, output index, output wdata, input rdata, input ready);
   modport bank  (input rd, input wr, input index, input wdata, output rdata, output ready);
endinterface : dlc_reg_if
`default_nettype wire

// ---- core/dlc_sync.sv ----
// Two-stage synchroniser for pin levels.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module dlc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q      <= '0;
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : dlc_sync
`default_nettype wire

// ---- core/dlc_avs_slave.sv ----
// Avalon-MM slave with waitrequest, turning bus cycles into strobes.
// Assumes a master that holds its request until waitrequest is low.
`timescale 1ns/10ps
`default_nettype none
module dlc_avs_slave
   import dlc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output var  logic [31:0] readdata,
   output var  logic        waitrequest,
   dlc_reg_if.slave         rif
);
   localparam int ANS_MAX = 5;

   logic ack_q;
   logic req;
   logic take;
   logic [7:0] rdata_q;

   assign req         = read | write;
   assign take        = req & ~ack_q & rif.ready & ce;
   assign waitrequest = req & ~ack_q;
   assign rif.index   = address[7:2];
   // Misaligned byte addresses land on no register
   assign rif.rd      = take & read;
   assign rif.wr      = take & write & ~read & byteenable[0] & (address[1:0] == 2'h0);
   assign rif.wdata   = writedata[7:0];
   assign readdata    = {24'h000000, rdata_q};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_q   <= 1'b0;
         rdata_q <= 8'h00;
      end else if (ce) begin
         ack_q <= take;
         if (take) begin
            rdata_q <= (address[1:0] == 2'h0) ? rif.rdata : 8'h00;
         end
      end
   end

   a_answer_bounded : assert property (@(posedge clk) disable iff (rst)
      (req && ce) |-> ##[0:ANS_MAX] !waitrequest)
      else $error("bus request not answered in time");
endmodule : dlc_avs_slave
`default_nettype wire

// ---- core/dlc_link_ctrl.sv ----
// Control and status register bank of a serial-link deserializer.
// Assumes one 25 MHz clock; pins arrive asynchronously and are synchronised here.
//
// What this block does
// - The sleep bit puts the device to sleep when 1, and after reset takes a value derived from two strap pins.
// - The two-bit interface field selects I2C on 00, UART on 01 and no peripheral interface on 10 or 11, resetting to 00.
// - The reverse channel enable lets the device send toward the serializer when 1 and resets to 1.
// - The forward channel enable lets the device receive from the serializer when 1 and resets to 1.
// - The address mode bit makes the converter send the register address on 0 and command bytes only on 1, resetting to 0.
// - The highpass field picks the equalizer cutoff and resets to 01, and the boost power-down bit disables boosting when set.
// - The gain field selects boost steps, codes 11XX must never be written, and after reset it is 0100 or 1001 by the gain strap pin.
// - The auto error clear bit makes error registers and outputs reset automatically when 1 and resets to 0.
// - The interrupt forward disable bit passes the interrupt pin to the serializer when 0 and blocks it when 1.
// - A read-only bit reports the current interrupt pin level and ignores writes.
// - One drive bit sets general-purpose pin 1 and resets to 1, and a read-only bit returns that pin's level.
// - Another drive bit sets general-purpose pin 0 and resets to 1, and a read-only bit returns that pin's level.
`timescale 1ns/10ps
`default_nettype none
module dlc_link_ctrl
   import dlc_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output var  logic [31:0] AVS_READDATA,
   output var  logic        AVS_WAITREQUEST,
   input  wire logic        CHANNEL_SIDE_PIN,
   input  wire logic        BASE_MODE_PIN,
   input  wire logic        GAIN_DEFAULT_PIN,
   input  wire logic        IRQ_IN,
   output var  logic        IRQ_FORWARD,
   output var  logic        SLEEP_MODE,
   output var  logic        PERIPH_I2C_EN,
   output var  logic        PERIPH_UART_EN,
   output var  logic        REVERSE_CHANNEL_ENABLE,
   output var  logic        FORWARD_CHANNEL_ENABLE,
   output var  logic        ADDRESS_SEND_MODE,
   output var  logic [1:0]  HIGHPASS_CUTOFF_SELECT,
   output var  logic        BOOST_POWER_DOWN,
   output var  logic [3:0]  BOOST_GAIN_SELECT,
   output var  logic        STAGGER_DISABLE,
   output var  logic        AUTO_ERROR_CLEAR,
   input  wire logic        PIN0_I,
   output var  logic        PIN0_O,
   output var  logic        PIN0_OE,
   input  wire logic        PIN1_I,
   output var  logic        PIN1_O,
   output var  logic        PIN1_OE
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic gain_legal(input logic [3:0] g);
      gain_legal = (g[3:2] != 2'h3);
   endfunction : gain_legal

   function automatic logic sleep_strap(input logic channel_side_pin, input logic ms);
      sleep_strap = ~channel_side_pin & ms;
   endfunction : sleep_strap

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave and pin synchronisers

   dlc_reg_if rif ();

   dlc_avs_slave u_slave (
      .clk         (SYS_CLK),
      .rst         (RST),
      .ce          (CE),
      .address     (AVS_ADDRESS),
      .read        (AVS_READ),
      .write       (AVS_WRITE),
      .writedata   (AVS_WRITEDATA),
      .byteenable  (AVS_BYTEENABLE),
      .readdata    (AVS_READDATA),
      .waitrequest (AVS_WAITREQUEST),
      .rif         (rif.slave)
   );

   logic [5:0] pins_s;
   logic       cds_s;
   logic       ms_s;
   logic       eqs_s;
   logic       irq_s;
   logic       pin0_s;
   logic       pin1_s;

   dlc_sync #(.W(6)) u_sync (
      .clk (SYS_CLK),
      .rst (RST),
      .ce  (CE),
      .d   ({CHANNEL_SIDE_PIN, BASE_MODE_PIN, GAIN_DEFAULT_PIN, IRQ_IN, PIN1_I, PIN0_I}),
      .q   (pins_s)
   );

   assign {cds_s, ms_s, eqs_s, irq_s, pin1_s, pin0_s} = pins_s;

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture after reset release

   dlc_strap_t st_q;
   dlc_strap_t st_d;
   logic       strap_load;

   always_comb begin
      case (st_q)
         DLC_ST_FILL0 : st_d = DLC_ST_FILL1;
         DLC_ST_FILL1 : st_d = DLC_ST_LOAD;
         DLC_ST_LOAD  : st_d = DLC_ST_RUN;
         DLC_ST_RUN   : st_d = DLC_ST_RUN;
         default      : st_d = DLC_ST_FILL0;
      endcase
   end

   // Synchronised straps are valid only from the third edge on
   assign strap_load = (st_q == DLC_ST_LOAD);
   assign rif.ready  = (st_q == DLC_ST_RUN);

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         st_q <= DLC_ST_FILL0;
      end else if (CE) begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register decode

   logic       wr_ctrl;
   logic       wr_eq;
   logic       wr_misc;
   logic [7:0] wd;

   assign wd      = rif.wdata;
   assign wr_ctrl = rif.wr & (rif.index == DLC_IDX_CTRL);
   assign wr_eq   = rif.wr & (rif.index == DLC_IDX_EQ);
   assign wr_misc = rif.wr & (rif.index == DLC_IDX_MISC);

   ////////////////////////////////////////////////////////////////////////////
   // Sleep and channel control

   logic       sleep_q;
   logic [1:0] iface_q;
   logic       rev_en_q;
   logic       fwd_en_q;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         sleep_q  <= DLC_RST_SLEEP;
         iface_q  <= DLC_RST_IFACE;
         rev_en_q <= DLC_RST_REV;
         fwd_en_q <= DLC_RST_FWD;
      end else if (CE) begin
         if (strap_load) begin
            sleep_q <= sleep_strap(cds_s, ms_s);
         end else if (wr_ctrl) begin
            sleep_q  <= wd[DLC_CTRL_SLEEP_BIT];
            iface_q  <= wd[DLC_CTRL_TYPE_LSB +: 2];
            rev_en_q <= wd[DLC_CTRL_REV_BIT];
            fwd_en_q <= wd[DLC_CTRL_FWD_BIT];
         end
      end
   end

   assign SLEEP_MODE             = sleep_q;
   assign PERIPH_I2C_EN          = (iface_q == DLC_IFACE_I2C);
   assign PERIPH_UART_EN         = (iface_q == DLC_IFACE_UART);
   assign REVERSE_CHANNEL_ENABLE = rev_en_q;
   assign FORWARD_CHANNEL_ENABLE = fwd_en_q;

   ////////////////////////////////////////////////////////////////////////////
   // Conversion and equalizer

   logic       addr_mode_q;
   logic [1:0] hpf_q;
   logic       boost_power_down_q;
   logic [3:0] gain_q;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         addr_mode_q <= DLC_RST_ADDR;
         hpf_q       <= DLC_RST_HPF;
         boost_power_down_q      <= DLC_RST_BOOST_POWER_DOWN;
         gain_q      <= DLC_GAIN_EQS_HI;
      end else if (CE) begin
         if (strap_load) begin
            gain_q <= eqs_s ? DLC_GAIN_EQS_HI : DLC_GAIN_EQS_LO;
         end else if (wr_eq) begin
            addr_mode_q <= wd[DLC_EQ_ADDR_BIT];
            hpf_q       <= wd[DLC_EQ_HPF_LSB +: 2];
            boost_power_down_q      <= wd[DLC_EQ_BOOST_POWER_DOWN_BIT];
            // Unusable gain codes never reach the equalizer
            if (gain_legal(wd[DLC_EQ_GAIN_LSB +: 4])) begin
               gain_q <= wd[DLC_EQ_GAIN_LSB +: 4];
            end
         end
      end
   end

   assign ADDRESS_SEND_MODE      = addr_mode_q;
   assign HIGHPASS_CUTOFF_SELECT = hpf_q;
   assign BOOST_POWER_DOWN       = boost_power_down_q;
   assign BOOST_GAIN_SELECT      = gain_q;

   ////////////////////////////////////////////////////////////////////////////
   // Miscellaneous: stagger, error clear, interrupt, pins

   logic stag_q;
   logic auto_q;
   logic irqd_q;
   logic p1_drv_q;
   logic p0_drv_q;
   logic irq_fwd_q;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         stag_q   <= DLC_RST_STAG;
         auto_q   <= DLC_RST_AUTO;
         irqd_q   <= DLC_RST_IRQD;
         p1_drv_q <= DLC_RST_PDRV;
         p0_drv_q <= DLC_RST_PDRV;
      end else if (CE && wr_misc) begin
         // Status bits 4, 2 and 0 of the write are dropped
         stag_q   <= wd[DLC_MISC_STAG_BIT];
         auto_q   <= wd[DLC_MISC_AUTO_BIT];
         irqd_q   <= wd[DLC_MISC_IRQD_BIT];
         p1_drv_q <= wd[DLC_MISC_P1DRV_BIT];
         p0_drv_q <= wd[DLC_MISC_P0DRV_BIT];
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         irq_fwd_q <= 1'b0;
      end else if (CE) begin
         irq_fwd_q <= irq_s & ~irqd_q;
      end
   end

   assign STAGGER_DISABLE  = stag_q;
   assign AUTO_ERROR_CLEAR = auto_q;
   assign IRQ_FORWARD      = irq_fwd_q;
   // Open drain: a pin reads back low when another party pulls it
   assign PIN1_O           = 1'b0;
   assign PIN1_OE          = ~p1_drv_q;
   assign PIN0_O           = 1'b0;
   assign PIN0_OE          = ~p0_drv_q;

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; status bits are live synchronised pin levels

   logic [7:0] rd_ctrl;
   logic [7:0] rd_eq;
   logic [7:0] rd_misc;

   assign rd_ctrl = {3'h0, sleep_q, iface_q, rev_en_q, fwd_en_q};
   assign rd_eq   = {addr_mode_q, hpf_q, boost_power_down_q, gain_q};
   assign rd_misc = {stag_q, auto_q, irqd_q, irq_s,
                     p1_drv_q, pin1_s, p0_drv_q, pin0_s};
   assign rif.rdata = (rif.index == DLC_IDX_CTRL) ? rd_ctrl :
                      (rif.index == DLC_IDX_EQ)   ? rd_eq   :
                      (rif.index == DLC_IDX_MISC) ? rd_misc : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   sequence s_ctrl_write;
      CE && wr_ctrl;
   endsequence

   sequence s_strap_taken;
      CE && strap_load ##1 1'b1;
   endsequence

   a_sleep_write : assert property (s_ctrl_write |=> SLEEP_MODE == $past(wd[DLC_CTRL_SLEEP_BIT]))
      else $error("sleep bit did not follow write");

   a_sleep_strap : assert property (s_strap_taken |-> SLEEP_MODE == (!$past(cds_s) && $past(ms_s)))
      else $error("sleep strap not captured");

   a_iface_select : assert property (s_ctrl_write |=>
      (PERIPH_UART_EN == ($past(wd[DLC_CTRL_TYPE_LSB +: 2]) == 2'h1)) &&
      (PERIPH_I2C_EN == ($past(wd[DLC_CTRL_TYPE_LSB +: 2]) == 2'h0)))
      else $error("interface select wrong");

   a_channel_enables : assert property (s_ctrl_write |=>
      REVERSE_CHANNEL_ENABLE == $past(wd[DLC_CTRL_REV_BIT]) &&
      FORWARD_CHANNEL_ENABLE == $past(wd[DLC_CTRL_FWD_BIT]))
      else $error("channel enable did not follow write");

   a_eq_fields : assert property ((CE && wr_eq) |=>
      ADDRESS_SEND_MODE == $past(wd[7]) && HIGHPASS_CUTOFF_SELECT == $past(wd[6:5]) &&
      BOOST_POWER_DOWN == $past(wd[4]))
      else $error("equalizer fields did not follow write");

   a_gain_guard : assert property ((CE && wr_eq && wd[3:2] == 2'h3) |=> $stable(BOOST_GAIN_SELECT))
      else $error("illegal gain code accepted");

   a_gain_strap : assert property (s_strap_taken |->
      BOOST_GAIN_SELECT == ($past(eqs_s) ? 4'h4 : 4'h9))
      else $error("gain strap not captured");

   a_auto_clear : assert property ((CE && wr_misc) |=> AUTO_ERROR_CLEAR == $past(wd[6]))
      else $error("auto clear did not follow write");

   a_irq_blocked : assert property (irqd_q && $past(irqd_q) |-> !IRQ_FORWARD)
      else $error("interrupt forwarded while disabled");

   a_status_live : assert property ((rif.rd && rif.index == DLC_IDX_MISC && AVS_ADDRESS[1:0] == 2'h0) |=>
      AVS_READDATA[4] == $past(irq_s) && AVS_READDATA[2] == $past(pin1_s) &&
      AVS_READDATA[0] == $past(pin0_s))
      else $error("status bits not live");

   a_pin_drive : assert property ((CE && wr_misc) |=>
      PIN1_OE == !$past(wd[3]) && PIN0_OE == !$past(wd[1]))
      else $error("pin drive did not follow write");

endmodule : dlc_link_ctrl
`default_nettype wire

// ---- bench/dlc_pin_env.sv ----
// Model of the board around the register bank: open-drain pins and interrupt source.
// Assumes pull-ups on both general-purpose pins; the bench may pull either pin low.
`timescale 1ns/10ps
`default_nettype none
module dlc_pin_env (
   input  wire logic pin0_oe,
   input  wire logic pin1_oe,
   input  wire logic ext0_low,
   input  wire logic ext1_low,
   input  wire logic irq_src,
   output var  logic pin0_i,
   output var  logic pin1_i,
   output var  logic irq_in
);
   // Released pin floats to the pull-up level, never holds its last value
   always_comb begin
      pin0_i = ~(pin0_oe | ext0_low);
      pin1_i = ~(pin1_oe | ext1_low);
      irq_in = irq_src;
   end
endmodule : dlc_pin_env
`default_nettype wire

// ---- bench/test_deserializer_link_control_regs.sv ----
// Self-checking bench for the link control register bank.
// Assumes the bank answers on Avalon-MM with waitrequest and one 25 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module test_deserializer_link_control_regs;
   import dlc_pkg::*;
   localparam logic [7:0] A_CTRL = 8'h10;
   localparam logic [7:0] A_EQ   = 8'h14;
   localparam logic [7:0] A_MISC = 8'h18;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  adr = 8'h00;
   logic        rd_q = 1'b0;
   logic        wr_q = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  ben = 4'h0;
   logic [31:0] rdat;
   logic        wreq;
   logic        channel_side_pin = 1'b1, ms = 1'b0, gain_default_pin = 1'b0, irq_src = 1'b0;
   logic        ext0 = 1'b0, ext1 = 1'b0;
   logic        ce = 1'b1;
   logic        irq_in, irq_fwd, sleep, i2c_en, uart_en, rev_en, fwd_en, adr_mode, boost_power_down, stag, auto_clr;
   logic [1:0]  hpf;
   logic [3:0]  gain;
   logic        p0_i, p0_o, p0_oe, p1_i, p1_o, p1_oe;
   logic [7:0]  tmp;
   logic [3:0]  exp_gain;
   int          err_count = 0;
   int          comparisons = 0;

   always #20 sys_clk = ~sys_clk;

   dlc_link_ctrl u_dlc_link_ctrl (.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .AVS_ADDRESS(adr),
      .AVS_READ(rd_q), .AVS_WRITE(wr_q), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(ben),
      .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .CHANNEL_SIDE_PIN(channel_side_pin), .BASE_MODE_PIN(ms),
      .GAIN_DEFAULT_PIN(gain_default_pin), .IRQ_IN(irq_in), .IRQ_FORWARD(irq_fwd), .SLEEP_MODE(sleep),
      .PERIPH_I2C_EN(i2c_en), .PERIPH_UART_EN(uart_en), .REVERSE_CHANNEL_ENABLE(rev_en),
      .FORWARD_CHANNEL_ENABLE(fwd_en), .ADDRESS_SEND_MODE(adr_mode), .HIGHPASS_CUTOFF_SELECT(hpf),
      .BOOST_POWER_DOWN(boost_power_down), .BOOST_GAIN_SELECT(gain), .STAGGER_DISABLE(stag),
      .AUTO_ERROR_CLEAR(auto_clr), .PIN0_I(p0_i), .PIN0_O(p0_o), .PIN0_OE(p0_oe),
      .PIN1_I(p1_i), .PIN1_O(p1_o), .PIN1_OE(p1_oe));

   dlc_pin_env u_dlc_pin_env (.pin0_oe(p0_oe), .pin1_oe(p1_oe), .ext0_low(ext0), .ext1_low(ext1),
      .irq_src(irq_src), .pin0_i(p0_i), .pin1_i(p1_i), .irq_in(irq_in));

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Request stands until a rising edge sees waitrequest low; data taken and request dropped there
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be,
                      output logic [7:0] r);
      int n;
      r = 8'h00;
      @(posedge sys_clk);
      adr  <= a;
      wdat <= {24'h0, d};
      ben  <= be;
      wr_q <= w;
      rd_q <= ~w;
      for (n = 0; n < 60; n++) begin
         @(posedge sys_clk);
         if (wreq === 1'b0) break;
      end
      if (n == 60) begin
         err_count++;
         $display("unexpected at %0t: bus cycle never answered", $time);
         tally_and_finish();
      end else begin
         r = rdat[7:0];
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end
   endtask : bus

   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1, tmp);
   endtask : wr8

   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] r;
      bus(1'b0, a, 8'h00, 4'hf, r);
      chk(r, exp, "read data");
   endtask : chk_rd

   task automatic do_reset(input logic c, input logic m, input logic e);
      @(posedge sys_clk);
      rst <= 1'b1;
      channel_side_pin <= c;
      ms  <= m;
      gain_default_pin <= e;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
   endtask : do_reset

   task automatic settle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : settle

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      $display("unexpected at %0t: run did not finish", $time);
      tally_and_finish();
   end

   initial begin
      do_reset(1'b1, 1'b0, 1'b0);
      chk_rd(A_CTRL, 8'h03);
      chk_rd(A_EQ, 8'h29);
      chk_rd(A_MISC, 8'h0f);
      settle(1);
      chk({sleep, i2c_en, uart_en, rev_en, fwd_en, adr_mode, stag, auto_clr}, 8'h58, "reset levels");
      chk({2'h0, p1_o, p0_o, irq_fwd, p1_oe, p0_oe, boost_power_down}, 8'h00, "reset pins");
      // Every interface code, sleep set, reverse channel off
      for (int i = 0; i < 4; i++) begin
         wr8(A_CTRL, {3'b000, 1'b1, i[1:0], 2'b01});
         settle(1);
         chk({3'h0, sleep, i2c_en, uart_en, rev_en, fwd_en}, {4'h1, i == 0, i == 1, 2'b01}, "ctrl outs");
         chk_rd(A_CTRL, {3'b000, 1'b1, i[1:0], 2'b01});
      end
      wr8(A_CTRL, 8'h02);
      settle(1);
      chk({6'h0, rev_en, fwd_en}, 8'h02, "channel enables");
      wr8(A_EQ, 8'hf3);
      settle(1);
      chk({adr_mode, hpf, boost_power_down, gain}, 8'hf3, "eq outs");
      // Gain sweep: codes 11xx must leave the previous gain in place
      exp_gain = 4'h3;
      for (int g = 0; g < 16; g++) begin
         wr8(A_EQ, {4'h2, g[3:0]});
         if (g < 12) exp_gain = g[3:0];
         chk_rd(A_EQ, {4'h2, exp_gain});
      end
      // Interrupt held back while forwarding is disabled
      irq_src <= 1'b1;
      wr8(A_MISC, 8'hff);
      settle(4);
      chk({5'h0, irq_fwd, stag, auto_clr}, 8'h03, "irq blocked");
      chk_rd(A_MISC, 8'hff);
      wr8(A_MISC, 8'h00);
      settle(4);
      chk({5'h0, irq_fwd, p1_oe, p0_oe}, 8'h07, "irq forwarded, pins low");
      chk_rd(A_MISC, 8'h10);
      wr8(A_MISC, 8'h15);
      chk_rd(A_MISC, 8'h10);
      irq_src <= 1'b0;
      settle(4);
      chk({7'h0, irq_fwd}, 8'h00, "irq dropped");
      chk_rd(A_MISC, 8'h00);
      // Pin pulled low from outside while released
      wr8(A_MISC, 8'h0a);
      ext1 <= 1'b1;
      settle(4);
      chk_rd(A_MISC, 8'h0b);
      @(posedge sys_clk);
      ext1 <= 1'b0;
      ext0 <= 1'b1;
      settle(4);
      chk_rd(A_MISC, 8'h0e);
      ext0 <= 1'b0;
      // Refused accesses
      wr8(A_CTRL + 8'h0c, 8'hff);
      chk_rd(A_CTRL + 8'h0c, 8'h00);
      chk_rd(A_CTRL + 8'h01, 8'h00);
      bus(1'b1, A_CTRL, 8'h1f, 4'he, tmp);
      chk_rd(A_CTRL, 8'h02);
      // Clock enable low: interrupt path must stay frozen
      ce      <= 1'b0;
      irq_src <= 1'b1;
      settle(6);
      chk({7'h0, irq_fwd}, 8'h00, "frozen by clock enable");
      @(posedge sys_clk);
      ce      <= 1'b1;
      irq_src <= 1'b0;
      // Second reset with the other strap levels
      do_reset(1'b0, 1'b1, 1'b1);
      chk_rd(A_CTRL, 8'h13);
      chk_rd(A_EQ, 8'h24);
      settle(1);
      chk({7'h0, sleep}, 8'h01, "strap sleep");
      tally_and_finish();
   end
endmodule : test_deserializer_link_control_regs
`default_nettype wire
